/* File: hdl/sleep_timer_pkg.sv */
/*
 * Constants and types shared by the sleep wake-up timer and battery monitor.
 * Assumes a 25 MHz system clock and a 32.768 kHz low-frequency time base.
 */
package sleep_timer_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_IRQ_STATUS1 = 7'h03;
	localparam logic [6:0] ADDR_IRQ_STATUS2 = 7'h04;
	localparam logic [6:0] ADDR_IRQ_ENABLE2 = 7'h06;
	localparam logic [6:0] ADDR_MODE_CTRL1 = 7'h07;
	localparam logic [6:0] ADDR_MODE_CTRL2 = 7'h08;
	localparam logic [6:0] ADDR_WAKEUP_EXPONENT = 7'h14;
	localparam logic [6:0] ADDR_WAKEUP_MANT_HIGH = 7'h15;
	localparam logic [6:0] ADDR_WAKEUP_MANT_LOW = 7'h16;
	localparam logic [6:0] ADDR_WAKEUP_COUNT_HIGH = 7'h17;
	localparam logic [6:0] ADDR_WAKEUP_COUNT_LOW = 7'h18;
	localparam logic [6:0] ADDR_RX_EXTENSION = 7'h19;
	localparam logic [6:0] ADDR_BATTERY_THRESHOLD = 7'h1a;
	localparam logic [6:0] ADDR_BATTERY_LEVEL = 7'h1b;

	localparam logic [7:0] RST_WAKEUP_EXPONENT = 8'h03;
	localparam logic [7:0] RST_BATTERY_THRESHOLD = 8'h14;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL1_XTAL_ON_BIT = 0;
	localparam int CTRL1_RX_ON_BIT = 2;
	localparam int CTRL1_EXT_LF_XTAL_BIT = 4;
	localparam int CTRL1_WAKEUP_EN_BIT = 5;
	localparam int CTRL1_BATTERY_EN_BIT = 6;
	localparam int CTRL2_DUTY_CYCLE_BIT = 2;
	localparam int IRQ2_BATTERY_BIT = 2;
	localparam int IRQ2_WAKEUP_BIT = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_HZ = 25000000;
	localparam int LF_CLK_HZ = 32768;
	localparam int BATTERY_PERIOD_MS = 1000;
	localparam int BATTERY_MEAS_US = 250;
	localparam int BATTERY_PERIOD_LF_TICKS = LF_CLK_HZ * BATTERY_PERIOD_MS / 1000;
	localparam int BATTERY_MEAS_CYCLES = SYS_CLK_HZ / 1000000 * BATTERY_MEAS_US;
	localparam logic [2:0] BATTERY_REQUIRED_HITS = 3'd4;
	localparam logic [33:0] WAKEUP_UNIT_TICKS = 34'd4;
	localparam logic [24:0] LF_PHASE_STEP = 25'd32768;
	localparam logic [24:0] LF_PHASE_WRAP = 25'd25000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic preamble_valid;
		logic sync_valid;
		logic window_done;
	} rx_detect_t;

	typedef enum logic [3:0] {
		ST_AWAKE = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_LISTEN = 4'b0100,
		ST_EXTEND = 4'b1000
	} power_state_t;

endpackage : sleep_timer_pkg

/* File: hdl/lf_scaled_counter.sv */
/*
 * Counts mantissa units of 4 x 2^exponent low-frequency ticks and pulses on expiry.
 * Assumes i_lf_tick is a one-cycle enable at the 32.768 kHz rate.
 */
`timescale 1ns/1ps
`default_nettype none
module lf_scaled_counter
	import sleep_timer_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_lf_tick,
	input wire logic i_run,
	input wire logic [4:0] i_exponent,
	input wire logic [15:0] i_mantissa,
	output logic [15:0] o_count,
	output logic o_expire
);

	logic [33:0] prescale;
	wire [33:0] prescale_last = (WAKEUP_UNIT_TICKS << i_exponent) - 34'd1;
	wire unit_done = i_run && i_lf_tick && (prescale == prescale_last);
	// A zero mantissa would otherwise expire after 65536 units, so it never expires.
	wire period_done = unit_done && (i_mantissa != 16'h0000) && (o_count == i_mantissa - 16'd1);

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prescale <= 34'd0;
			o_count <= 16'h0000;
			o_expire <= 1'b0;
		end else begin
			o_expire <= period_done;
			if (!i_run) begin
				prescale <= 34'd0;
				o_count <= 16'h0000;
			end else if (i_lf_tick) begin
				prescale <= unit_done ? 34'd0 : prescale + 34'd1;
				if (period_done) begin
					o_count <= 16'h0000;
				end else if (unit_done) begin
					o_count <= o_count + 16'd1;
				end
			end
		end
	end

endmodule : lf_scaled_counter
`default_nettype wire

/* File: hdl/sleep_wakeup_timer_battery_monitor.sv */
/*
 * Sleep wake-up timer, low battery monitor and low duty cycle receive sequencing.
 * Assumes the register port and all pins are synchronous to i_sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_timer_battery_monitor
	import sleep_timer_pkg::*;
#(
	parameter int BATTERY_PERIOD_TICKS = BATTERY_PERIOD_LF_TICKS,
	parameter int BATTERY_MEAS_CLOCKS = BATTERY_MEAS_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire reg_req_t i_reg_req,
	output logic [7:0] o_reg_rdata,
	input wire logic i_lf_xtal_tick,
	input wire logic [4:0] i_battery_code,
	input wire rx_detect_t i_rx_detect,
	output logic o_interrupt_out_n,
	output logic o_xtal_on,
	output logic o_host_clk_en,
	output logic o_rx_on,
	output logic o_rc_osc_on,
	output logic o_ext_lf_xtal_mode,
	output logic o_battery_detector_on,
	output logic o_wakeup_gpio
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] irq_status2;
	logic [7:0] irq_enable2;
	logic [7:0] mode_ctrl1;
	logic [7:0] mode_ctrl2;
	logic [7:0] wakeup_period_exponent;
	logic [7:0] wakeup_period_mantissa_high;
	logic [7:0] wakeup_period_mantissa_low;
	logic [7:0] rx_extension_duration;
	logic [7:0] battery_threshold;
	logic [4:0] battery_level;

	wire wr_en = i_reg_req.wr;
	wire [6:0] addr = i_reg_req.addr;
	wire status2_read = i_reg_req.rd && (addr == ADDR_IRQ_STATUS2);

	wire external_lf_crystal_select = mode_ctrl1[CTRL1_EXT_LF_XTAL_BIT];
	wire battery_enable = mode_ctrl1[CTRL1_BATTERY_EN_BIT];
	wire wakeup_enable = mode_ctrl1[CTRL1_WAKEUP_EN_BIT];
	wire commanded_sleep = !mode_ctrl1[CTRL1_XTAL_ON_BIT] && !mode_ctrl1[CTRL1_RX_ON_BIT];
	wire duty_cycle_enable = mode_ctrl2[CTRL2_DUTY_CYCLE_BIT];
	wire [4:0] shared_exponent = wakeup_period_exponent[4:0];

	// ----------------------------------------------------------------
	// Low-frequency time base
	// ----------------------------------------------------------------
	// A phase accumulator gives the 32.768 kHz rate on average; a plain divider
	// by 763 would drift about 0.008 percent, which the period formula would show.
	logic [24:0] lf_phase;
	logic rc_tick;
	power_state_t state;
	wire in_sleep = (state != ST_AWAKE);
	wire [24:0] lf_phase_sum = lf_phase + LF_PHASE_STEP;
	wire rc_phase_wrap = (lf_phase_sum >= LF_PHASE_WRAP);
	wire lf_tick = external_lf_crystal_select ? i_lf_xtal_tick : rc_tick;
	wire rc_needed = (battery_enable || wakeup_enable || duty_cycle_enable) && !external_lf_crystal_select;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lf_phase <= 25'd0;
			rc_tick <= 1'b0;
		end else if (o_rc_osc_on) begin
			lf_phase <= rc_phase_wrap ? lf_phase_sum - LF_PHASE_WRAP : lf_phase_sum;
			rc_tick <= rc_phase_wrap;
		end else begin
			rc_tick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Wake-up timer and receive extension
	// ----------------------------------------------------------------
	logic wakeup_armed;
	logic [15:0] wakeup_count;
	logic wakeup_expire;
	logic extend_expire;

	lf_scaled_counter u_wakeup_timer (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.i_lf_tick(lf_tick),
		.i_run(wakeup_armed && in_sleep),
		.i_exponent(shared_exponent),
		.i_mantissa({wakeup_period_mantissa_high, wakeup_period_mantissa_low}),
		.o_count(wakeup_count),
		.o_expire(wakeup_expire)
	);

	lf_scaled_counter u_rx_extension (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.i_lf_tick(lf_tick),
		.i_run(state == ST_EXTEND),
		.i_exponent(shared_exponent),
		.i_mantissa({8'h00, rx_extension_duration}),
		.o_count(),
		.o_expire(extend_expire)
	);

	// ----------------------------------------------------------------
	// Battery detector sequencing
	// ----------------------------------------------------------------
	logic [15:0] battery_tick_count;
	logic [15:0] battery_meas_count;
	logic [2:0] battery_hits;
	wire battery_period_done = battery_enable && lf_tick
		&& (battery_tick_count == 16'(BATTERY_PERIOD_TICKS - 1));
	wire battery_meas_done = o_battery_detector_on
		&& (battery_meas_count == 16'(BATTERY_MEAS_CLOCKS - 1));
	wire battery_below = (i_battery_code < battery_threshold[4:0]);
	wire [2:0] next_battery_hits = !battery_below ? 3'd0 :
		(battery_hits == BATTERY_REQUIRED_HITS) ? battery_hits : battery_hits + 3'd1;
	wire battery_event = battery_meas_done && battery_below
		&& (battery_hits == BATTERY_REQUIRED_HITS - 3'd1);

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			battery_tick_count <= 16'h0000;
			battery_meas_count <= 16'h0000;
			battery_hits <= 3'd0;
			battery_level <= 5'd0;
			o_battery_detector_on <= 1'b0;
		end else if (!battery_enable) begin
			battery_tick_count <= 16'h0000;
			battery_meas_count <= 16'h0000;
			battery_hits <= 3'd0;
			o_battery_detector_on <= 1'b0;
		end else begin
			if (lf_tick) begin
				battery_tick_count <= battery_period_done ? 16'h0000 : battery_tick_count + 16'd1;
			end
			if (battery_period_done) begin
				o_battery_detector_on <= 1'b1;
			end else if (battery_meas_done) begin
				o_battery_detector_on <= 1'b0;
			end
			battery_meas_count <= o_battery_detector_on && !battery_meas_done ? battery_meas_count + 16'd1 : 16'h0000;
			if (battery_meas_done) begin
				battery_level <= i_battery_code;
				battery_hits <= next_battery_hits;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	wire irq_pending = !o_interrupt_out_n;
	wire wakeup_irq_enabled = irq_enable2[IRQ2_WAKEUP_BIT];
	wire both_found = i_rx_detect.preamble_valid && i_rx_detect.sync_valid;
	power_state_t next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_AWAKE: begin
				// Leaving for sleep waits until every pending interrupt has been read.
				if (commanded_sleep && !irq_pending) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!commanded_sleep) begin
					next_state = ST_AWAKE;
				end else if (wakeup_expire && duty_cycle_enable) begin
					next_state = ST_LISTEN;
				end
			end
			ST_LISTEN: begin
				if (!commanded_sleep) begin
					next_state = ST_AWAKE;
				end else if (both_found) begin
					next_state = ST_EXTEND;
				end else if (i_rx_detect.window_done) begin
					next_state = ST_SLEEP;
				end
			end
			ST_EXTEND: begin
				if (!commanded_sleep) begin
					next_state = ST_AWAKE;
				end else if (extend_expire) begin
					next_state = ST_SLEEP;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= ST_AWAKE;
			wakeup_armed <= 1'b0;
			o_wakeup_gpio <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_AWAKE && next_state == ST_SLEEP) begin
				wakeup_armed <= wakeup_enable;
			end else if (next_state == ST_AWAKE) begin
				wakeup_armed <= 1'b0;
			end
			// Without the interrupt the expiry marks the pin and the masked status bit; state moves only when duty cycling is on.
			o_wakeup_gpio <= wakeup_expire && !wakeup_irq_enabled;
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	wire [7:0] status2_set = ({7'h00, wakeup_expire} << IRQ2_WAKEUP_BIT)
		| ({7'h00, battery_event} << IRQ2_BATTERY_BIT);
	// A new event in the same cycle as the status read stays set.
	wire [7:0] next_irq_status2 = (status2_read ? 8'h00 : irq_status2) | status2_set;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_status2 <= RST_ZERO;
			irq_enable2 <= RST_ZERO;
			mode_ctrl1 <= RST_ZERO;
			mode_ctrl2 <= RST_ZERO;
			wakeup_period_exponent <= RST_WAKEUP_EXPONENT;
			wakeup_period_mantissa_high <= RST_ZERO;
			wakeup_period_mantissa_low <= RST_ZERO;
			rx_extension_duration <= RST_ZERO;
			battery_threshold <= RST_BATTERY_THRESHOLD;
		end else begin
			irq_status2 <= next_irq_status2;
			if (wr_en) begin
				unique case (addr)
					ADDR_IRQ_ENABLE2: irq_enable2 <= i_reg_req.wdata;
					ADDR_MODE_CTRL1: mode_ctrl1 <= i_reg_req.wdata;
					ADDR_MODE_CTRL2: mode_ctrl2 <= i_reg_req.wdata;
					ADDR_WAKEUP_EXPONENT: wakeup_period_exponent <= {3'b000, i_reg_req.wdata[4:0]};
					ADDR_WAKEUP_MANT_HIGH: wakeup_period_mantissa_high <= i_reg_req.wdata;
					ADDR_WAKEUP_MANT_LOW: wakeup_period_mantissa_low <= i_reg_req.wdata;
					ADDR_RX_EXTENSION: rx_extension_duration <= i_reg_req.wdata;
					ADDR_BATTERY_THRESHOLD: battery_threshold <= {3'b000, i_reg_req.wdata[4:0]};
					default: ;
				endcase
			end
		end
	end

	logic [7:0] read_mux;
	always_comb begin
		unique case (addr)
			ADDR_IRQ_STATUS2: read_mux = irq_status2;
			ADDR_IRQ_ENABLE2: read_mux = irq_enable2;
			ADDR_MODE_CTRL1: read_mux = mode_ctrl1;
			ADDR_MODE_CTRL2: read_mux = mode_ctrl2;
			ADDR_WAKEUP_EXPONENT: read_mux = wakeup_period_exponent;
			ADDR_WAKEUP_MANT_HIGH: read_mux = wakeup_period_mantissa_high;
			ADDR_WAKEUP_MANT_LOW: read_mux = wakeup_period_mantissa_low;
			ADDR_WAKEUP_COUNT_HIGH: read_mux = wakeup_count[15:8];
			ADDR_WAKEUP_COUNT_LOW: read_mux = wakeup_count[7:0];
			ADDR_RX_EXTENSION: read_mux = rx_extension_duration;
			ADDR_BATTERY_THRESHOLD: read_mux = battery_threshold;
			ADDR_BATTERY_LEVEL: read_mux = {3'b000, battery_level};
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_req.rd) begin
			o_reg_rdata <= read_mux;
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	assign o_interrupt_out_n = !(|(irq_status2 & irq_enable2));
	// The crystal stays up while an interrupt waits, so the host has a clock to serve it.
	assign o_xtal_on = (state == ST_AWAKE) || (state == ST_LISTEN) || (state == ST_EXTEND) || irq_pending;
	assign o_host_clk_en = o_xtal_on;
	assign o_rx_on = ((state == ST_AWAKE) && mode_ctrl1[CTRL1_RX_ON_BIT]) || (state == ST_LISTEN) || (state == ST_EXTEND);
	assign o_rc_osc_on = rc_needed && (in_sleep || battery_enable);
	assign o_ext_lf_xtal_mode = external_lf_crystal_select;

endmodule : sleep_wakeup_timer_battery_monitor
`default_nettype wire

/* File: verif/sleep_timer_chk.sv */
/* Port checker for the sleep timer and battery monitor.
 * Assumes a bind to the top module and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module sleep_timer_chk
	import sleep_timer_pkg::*;
#(
	parameter int BATTERY_MEAS_CLOCKS = BATTERY_MEAS_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire reg_req_t i_reg_req,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_interrupt_out_n,
	input wire logic o_xtal_on,
	input wire logic o_host_clk_en,
	input wire logic o_rc_osc_on,
	input wire logic o_ext_lf_xtal_mode,
	input wire logic o_battery_detector_on,
	input wire logic o_wakeup_gpio
);
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	// A counter keeps the window check cheap for any window length.
	logic [15:0] on_cnt;
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) on_cnt <= 16'h0000;
		else on_cnt <= o_battery_detector_on ? on_cnt + 16'h0001 : 16'h0000;
	end
	a_meas_window_len: assert property ($fell(o_battery_detector_on) |-> on_cnt == 16'(BATTERY_MEAS_CLOCKS))
		else $error("detector window length wrong");
	a_gpio_one_cycle: assert property (o_wakeup_gpio |=> !o_wakeup_gpio)
		else $error("wake pulse too long");
	a_gpio_keeps_state: assert property (o_wakeup_gpio && !i_reg_req.wr |=> $stable(o_xtal_on))
		else $error("state moved on masked expiry");
	a_host_clk_tied: assert property (o_host_clk_en == o_xtal_on)
		else $error("host clock apart from crystal");
	a_irq_keeps_clock: assert property (!o_interrupt_out_n |-> o_host_clk_en)
		else $error("host clock off while interrupt pending");
	a_ext_stops_rc: assert property (o_ext_lf_xtal_mode |-> !o_rc_osc_on)
		else $error("oscillator on in crystal mode");
	a_ext_follows_write: assert property (i_reg_req.wr && i_reg_req.addr == ADDR_MODE_CTRL1 |=>
		o_ext_lf_xtal_mode == $past(i_reg_req.wdata[CTRL1_EXT_LF_XTAL_BIT])) else $error("crystal select missed");
	a_level_top_zero: assert property (i_reg_req.rd && i_reg_req.addr == ADDR_BATTERY_LEVEL |=>
		o_reg_rdata[7:5] == 3'h0) else $error("level upper bits set");
	a_rdata_holds: assert property (!i_reg_req.rd |=> $stable(o_reg_rdata))
		else $error("read data moved without read");
	c_irq: cover property ($fell(o_interrupt_out_n));
	c_gpio: cover property (o_wakeup_gpio);
	c_meas: cover property ($fell(o_battery_detector_on));
endmodule : sleep_timer_chk
`default_nettype wire

/* File: verif/host_model.sv */
/* Host microcontroller model driving the register port.
 * Assumes the block takes one request per rising edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model
	import sleep_timer_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic [7:0] i_reg_rdata,
	output var reg_req_t o_reg_req
);
	initial o_reg_req = '0;
	// Released lines carry inverted values so a stale request is never read as fresh.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		o_reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_sys_clk);
		o_reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		o_reg_req <= '{addr: a, wdata: 8'h5a, wr: 1'b0, rd: 1'b1};
		@(posedge i_sys_clk);
		o_reg_req <= '{addr: ~a, wdata: 8'ha5, wr: 1'b0, rd: 1'b0};
		@(posedge i_sys_clk);
		d = i_reg_rdata;
	endtask : rd
	task automatic set_mode(input logic [7:0] d);
		wr(ADDR_MODE_CTRL1, d);
	endtask : set_mode
	task automatic service(output logic [7:0] st2);
		logic [7:0] st1;
		rd(ADDR_IRQ_STATUS1, st1);
		rd(ADDR_IRQ_STATUS2, st2);
	endtask : service
endmodule : host_model
`default_nettype wire

/* File: verif/tb.sv */
/* Self-checking bench for the sleep timer and battery monitor.
 * Assumes the host model owns the register port; the bench makes crystal ticks. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb
	import sleep_timer_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, bat_q = 1'b0;
	logic [2:0] div = 3'h0;
	logic [4:0] code = 5'h10;
	wire logic [7:0] rdata;
	logic [7:0] v;
	wire logic irq_n, xtal, hclk, rx, rc, ext, bat, gpio;
	rx_detect_t det = '0;
	wire reg_req_t req;
	int miscompares = 0, samples_checked = 0, ticks = 0, meas = 0, t0;
	always #20 clk = ~clk;
	// Crystal ticks every eight clocks keep long periods short in cycles.
	always @(posedge clk) begin
		div <= div + 3'h1;
		tick <= (div == 3'h7);
		bat_q <= bat;
		ticks <= ticks + int'(tick);
		meas <= meas + int'(bat && !bat_q);
	end
	host_model host (.i_sys_clk(clk), .i_reg_rdata(rdata), .o_reg_req(req));
	sleep_wakeup_timer_battery_monitor #(.BATTERY_PERIOD_TICKS(8), .BATTERY_MEAS_CLOCKS(4)) DUT (
		.i_sys_clk(clk), .i_arst_n(rst_n), .i_reg_req(req), .o_reg_rdata(rdata), .i_lf_xtal_tick(tick),
		.i_battery_code(code), .i_rx_detect(det), .o_interrupt_out_n(irq_n), .o_xtal_on(xtal),
		.o_host_clk_en(hclk), .o_rx_on(rx), .o_rc_osc_on(rc), .o_ext_lf_xtal_mode(ext),
		.o_battery_detector_on(bat), .o_wakeup_gpio(gpio));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic wait_sig(input int k, input logic lvl, input int lim);
		logic [3:0] s;
		repeat (lim) begin
			@(posedge clk);
			s = {gpio, rx, bat, irq_n};
			if (s[k] === lvl) return;
		end
		miscompares++;
		$display("ERROR wait %0d expected %0h seen %0h", k, lvl, s[k]);
		wrap_up();
	endtask : wait_sig
	task automatic t_regs();
		logic [6:0] a[5] = '{ADDR_WAKEUP_EXPONENT, ADDR_WAKEUP_MANT_HIGH, ADDR_WAKEUP_MANT_LOW,
			ADDR_BATTERY_THRESHOLD, 7'h7f};
		logic [7:0] e[5] = '{8'h03, 8'h00, 8'h00, 8'h14, 8'h00};
		`CHK("irq_n", 1'b1, irq_n)
		foreach (a[i]) begin
			host.rd(a[i], v);
			`CHK("reset value", e[i], v)
		end
		$display("test regs done");
	endtask : t_regs
	task automatic t_battery();
		host.wr(ADDR_BATTERY_THRESHOLD, 8'h10);
		host.wr(ADDR_IRQ_ENABLE2, 8'h04);
		host.set_mode(8'h51);
		repeat (400) @(posedge clk);
		`CHK("irq at threshold", 1'b1, irq_n)
		`CHK("rc in crystal mode", 1'b0, rc)
		`CHK("ext mode", 1'b1, ext)
		wait_sig(1, 1'b0, 100);
		code <= 5'h0f;
		t0 = meas;
		wait_sig(0, 1'b0, 2000);
		`CHK("readings", 4, meas - t0)
		host.service(v);
		`CHK("battery status", 1'b1, v[IRQ2_BATTERY_BIT])
		`CHK("irq after read", 1'b1, irq_n)
		host.rd(ADDR_BATTERY_LEVEL, v);
		`CHK("level", 8'h0f, v)
		host.set_mode(8'h40);
		repeat (3) @(posedge clk);
		`CHK("rc in sleep", 1'b1, rc)
		host.set_mode(8'h11);
		$display("test battery done");
	endtask : t_battery
	task automatic t_wake();
		host.wr(ADDR_WAKEUP_EXPONENT, 8'h00);
		host.wr(ADDR_WAKEUP_MANT_LOW, 8'h02);
		host.wr(ADDR_IRQ_ENABLE2, 8'h08);
		t0 = ticks;
		host.set_mode(8'h30);
		repeat (3) @(posedge clk);
		`CHK("xtal asleep", 1'b0, xtal)
		wait_sig(0, 1'b0, 1000);
		`CHK("period", 1'b1, (ticks - t0) inside {[8:9]})
		`CHK("xtal on expiry", 1'b1, xtal)
		`CHK("host clock on expiry", 1'b1, hclk)
		host.service(v);
		`CHK("wake status", 1'b1, v[IRQ2_WAKEUP_BIT])
		`CHK("xtal after read", 1'b0, xtal)
		host.set_mode(8'h11);
		$display("test wake done");
	endtask : t_wake
	task automatic t_gpio();
		host.wr(ADDR_IRQ_ENABLE2, 8'h00);
		host.wr(ADDR_WAKEUP_EXPONENT, 8'h01);
		host.wr(ADDR_WAKEUP_MANT_LOW, 8'h10);
		t0 = ticks;
		host.set_mode(8'h30);
		repeat (320) @(posedge clk);
		host.rd(ADDR_WAKEUP_COUNT_HIGH, v);
		`CHK("count high", 8'h00, v)
		host.rd(ADDR_WAKEUP_COUNT_LOW, v);
		`CHK("count low", 1'b1, v inside {[8'h04:8'h06]})
		wait_sig(3, 1'b1, 1500);
		`CHK("long period", 1'b1, (ticks - t0) inside {[128:129]})
		repeat (2) @(posedge clk);
		`CHK("xtal kept", 1'b0, xtal)
		`CHK("irq masked", 1'b1, irq_n)
		host.service(v);
		host.set_mode(8'h11);
		$display("test gpio done");
	endtask : t_gpio
	task automatic t_duty();
		host.wr(ADDR_WAKEUP_EXPONENT, 8'h00);
		host.wr(ADDR_WAKEUP_MANT_LOW, 8'h01);
		host.wr(ADDR_RX_EXTENSION, 8'h02);
		host.wr(ADDR_MODE_CTRL2, 8'h04);
		host.set_mode(8'h30);
		wait_sig(2, 1'b1, 200);
		det <= '{preamble_valid: 1'b1, sync_valid: 1'b0, window_done: 1'b1};
		@(posedge clk);
		det <= '0;
		repeat (2) @(posedge clk);
		`CHK("rx after miss", 1'b0, rx)
		wait_sig(2, 1'b1, 200);
		det <= '{preamble_valid: 1'b1, sync_valid: 1'b1, window_done: 1'b0};
		t0 = ticks;
		@(posedge clk);
		det <= '0;
		wait_sig(2, 1'b0, 500);
		`CHK("extension", 1'b1, (ticks - t0) inside {[8:9]})
		host.wr(ADDR_MODE_CTRL2, 8'h00);
		host.set_mode(8'h11);
		$display("test duty done");
	endtask : t_duty
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_battery();
		t_wake();
		t_gpio();
		t_duty();
		wrap_up();
	end
endmodule : tb
bind sleep_wakeup_timer_battery_monitor sleep_timer_chk #(.BATTERY_MEAS_CLOCKS(BATTERY_MEAS_CLOCKS)) u_chk (
	.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
	.o_interrupt_out_n(o_interrupt_out_n), .o_xtal_on(o_xtal_on), .o_host_clk_en(o_host_clk_en),
	.o_rc_osc_on(o_rc_osc_on), .o_ext_lf_xtal_mode(o_ext_lf_xtal_mode),
	.o_battery_detector_on(o_battery_detector_on), .o_wakeup_gpio(o_wakeup_gpio));
`default_nettype wire
